// file: rtl/pwf_defines.svh
`ifndef PWF_DEFINES_SVH
`define PWF_DEFINES_SVH
// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define PWF_REG_CTRL 8'h00
`define PWF_REG_ADDR 8'h04
`define PWF_REG_WDATA 8'h08
`define PWF_REG_CMD 8'h0C
`define PWF_REG_STATUS 8'h10
`define PWF_REG_RDATA 8'h14
// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define PWF_CTRL_SDP 0
`define PWF_CTRL_SHORT_ID 1
`define PWF_CTRL_RST 2'h0
`define PWF_ST_BUSY 0
`define PWF_ST_WIN 1
`define PWF_ST_ERR_PAGE 2
`define PWF_ST_ERR_TMO 3
`define PWF_ST_ERR_REF 4
// ----------------------------------------------------------------
// Timing, in printed units, and derived cycle counts
// ----------------------------------------------------------------
`define PWF_CLK_NS 20
`define PWF_WE_MIN_NS 15
`define PWF_RD_ACC_NS 120
`define PWF_WIN_US 150
`define PWF_PROG_MS 10
`define PWF_ERASE_MS 50
`define PWF_PAUSE_US 10
`define PWF_WE_CYC ((`PWF_WE_MIN_NS + `PWF_CLK_NS - 1) / `PWF_CLK_NS)
`define PWF_RD_CYC ((`PWF_RD_ACC_NS + `PWF_CLK_NS - 1) / `PWF_CLK_NS)
`define PWF_WIN_CYC ((`PWF_WIN_US * 1000) / `PWF_CLK_NS)
`define PWF_PROG_CYC ((`PWF_PROG_MS * 1000000 + `PWF_CLK_NS - 1) / `PWF_CLK_NS)
`define PWF_ERASE_CYC ((`PWF_ERASE_MS * 1000000 + `PWF_CLK_NS - 1) / `PWF_CLK_NS)
`define PWF_PAUSE_CYC ((`PWF_PAUSE_US * 1000 + `PWF_CLK_NS - 1) / `PWF_CLK_NS)
`define PWF_WIN_MARGIN 13'h0010
// ----------------------------------------------------------------
// Command addresses and bytes
// ----------------------------------------------------------------
`define PWF_CA_ODD 16'h5555
`define PWF_CA_EVEN 16'h2AAA
`define PWF_CB_UNLOCK1 8'hAA
`define PWF_CB_UNLOCK2 8'h55
`define PWF_CB_EXTEND 8'h80
`define PWF_CB_PROT_EN 8'hA0
`define PWF_CB_PROT_DIS 8'h20
`define PWF_CB_ERASE 8'h10
`define PWF_CB_ID_LONG 8'h60
`define PWF_CB_ID_SHORT 8'h90
`define PWF_CB_ID_EXIT 8'hF0
`endif

// file: rtl/pwf_pkg.sv
package pwf_pkg;
   typedef enum logic [2:0] {
      PWF_ST_IDLE = 3'b000,
      PWF_ST_SETUP = 3'b001,
      PWF_ST_STROBE = 3'b010,
      PWF_ST_HOLD = 3'b011,
      PWF_ST_READ = 3'b100,
      PWF_ST_PAUSE = 3'b101
   } pwf_state_e;
   typedef enum logic [2:0] {
      PWF_OP_READ = 3'b000,
      PWF_OP_LOAD = 3'b001,
      PWF_OP_PROT_DIS = 3'b010,
      PWF_OP_ERASE = 3'b011,
      PWF_OP_ID_ENTRY = 3'b100,
      PWF_OP_ID_EXIT = 3'b101,
      PWF_OP_HW_ID = 3'b110,
      PWF_OP_NONE = 3'b111
   } pwf_op_e;
endpackage

// file: rtl/pwf_sync.sv
// Three-stage synchroniser; the output follows once stages two and three agree.
module pwf_sync #(
   parameter int WIDTH = 8
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] stable_out
);
   logic [WIDTH-1:0] s1_q, s2_q, s3_q, out_q;
   // Only the second stage reads the first.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
         out_q <= '0;
      end else if (clk_en) begin
         s1_q <= async_in;
         s2_q <= s1_q;
         s3_q <= s2_q;
         if (s2_q == s3_q) begin
            out_q <= s3_q;
         end
      end
   end
   assign stable_out = out_q;
endmodule

// file: rtl/pwf_ctrl.sv
// The register addresses and the APB slave port were chosen for this implementation.
`include "pwf_defines.svh"
module pwf_ctrl
   import pwf_pkg::*;
#(
   parameter int unsigned RD_CYC = `PWF_RD_CYC,
   parameter int unsigned WIN_CYC = `PWF_WIN_CYC,
   parameter int unsigned PROG_CYC = `PWF_PROG_CYC,
   parameter int unsigned ERASE_CYC = `PWF_ERASE_CYC
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic [15:0] address_pins,
   input wire logic [7:0] data_pins_rd,
   output logic [7:0] data_pins_wr,
   output logic data_pins_oe,
   output logic chip_sel_n,
   output logic out_gate_n,
   output logic write_strobe_n,
   output logic id_high_voltage_pin
);
   // ----------------------------------------------------------------
   // Parameter checks
   // ----------------------------------------------------------------
   if (WIN_CYC <= 32 || WIN_CYC >= 8192 || RD_CYC < 1 || RD_CYC > 500 || PROG_CYC < 1 ||
       PROG_CYC >= 4194304 || ERASE_CYC < 1 || ERASE_CYC >= 4194304) begin : g_bad_param
      $error("pwf_ctrl: timing parameter out of range");
   end

   pwf_state_e st_q;
   pwf_op_e op_q;
   logic [2:0] step_q, ncmd_q;
   logic has_data_q;
   logic [9:0] cnt_q;
   logic [1:0] ctrl_q;
   logic [15:0] addr_q, job_addr_q, last_addr_q;
   logic [7:0] wdata_q, job_data_q, last_data_q, rdata_q, loads_q;
   logic err_page_q, err_tmo_q, err_ref_q;
   logic win_q, poll_q, poll_first_q, poll_erase_q, prev6_q;
   logic [12:0] win_cnt_q;
   logic [8:0] page_q;
   logic [21:0] tmo_q;
   logic [15:0] addr_pins_q;
   logic [7:0] dout_q;
   logic doe_q, ce_n_q, oe_n_q, we_n_q, hv_q;
   logic [31:0] prdata_q;
   logic pready_q, pslverr_q;
   logic [7:0] data_sync;

   // Pins leave the chip domain through three stages.
   pwf_sync #(.WIDTH(8)) u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .clk_en(clk_en),
      .async_in(data_pins_rd),
      .stable_out(data_sync)
   );

   // ----------------------------------------------------------------
   // Register decode
   // ----------------------------------------------------------------
   wire hit_ctrl = paddr == `PWF_REG_CTRL;
   wire hit_addr = paddr == `PWF_REG_ADDR;
   wire hit_wdata = paddr == `PWF_REG_WDATA;
   wire hit_cmd = paddr == `PWF_REG_CMD;
   wire hit_status = paddr == `PWF_REG_STATUS;
   wire hit_rdata = paddr == `PWF_REG_RDATA;
   wire mapped = hit_ctrl | hit_addr | hit_wdata | hit_cmd | hit_status | hit_rdata;
   wire acc_wr = psel & penable & pwrite & pready_q & clk_en;
   wire busy = (st_q != PWF_ST_IDLE) | poll_q;
   wire [31:0] status_w = {16'h0000, loads_q, 3'b000, err_ref_q, err_tmo_q, err_page_q, win_q, busy};
   wire [31:0] rd_val = hit_ctrl ? {30'h0, ctrl_q} : hit_addr ? {16'h0000, addr_q} :
                        hit_wdata ? {24'h0, wdata_q} : hit_status ? status_w :
                        hit_rdata ? {24'h0, rdata_q} : 32'h0;

   // ----------------------------------------------------------------
   // Command acceptance
   // ----------------------------------------------------------------
   wire cmd_go = acc_wr & hit_cmd;
   wire pwf_op_e cmd_op = pwf_op_e'(pwdata[2:0]);
   wire expire = win_q & (win_cnt_q <= `PWF_WIN_MARGIN);
   wire page_bad = win_q & (cmd_op == PWF_OP_LOAD) & (addr_q[15:7] != page_q);
   wire refuse = busy | (cmd_op == PWF_OP_NONE) | (win_q & ((cmd_op != PWF_OP_LOAD) | expire));
   wire start = cmd_go & ~refuse & ~page_bad;
   // Prefix length per order: protected loads of a new page carry three writes.
   wire [2:0] ncmd_w = (cmd_op == PWF_OP_LOAD) ? ((ctrl_q[`PWF_CTRL_SDP] & ~win_q) ? 3'd3 : 3'd0) :
                       (cmd_op == PWF_OP_PROT_DIS || cmd_op == PWF_OP_ERASE) ? 3'd6 :
                       (cmd_op == PWF_OP_ID_ENTRY) ? (ctrl_q[`PWF_CTRL_SHORT_ID] ? 3'd3 : 3'd6) :
                       (cmd_op == PWF_OP_ID_EXIT) ? 3'd3 : 3'd0;
   wire has_data_w = (cmd_op == PWF_OP_READ) | (cmd_op == PWF_OP_LOAD) | (cmd_op == PWF_OP_HW_ID);

   // ----------------------------------------------------------------
   // Command byte tables
   // ----------------------------------------------------------------
   wire in_cmd = ~poll_q & (step_q < ncmd_q);
   wire [7:0] last_byte = (op_q == PWF_OP_LOAD) ? `PWF_CB_PROT_EN :
                          (op_q == PWF_OP_PROT_DIS) ? `PWF_CB_PROT_DIS :
                          (op_q == PWF_OP_ERASE) ? `PWF_CB_ERASE :
                          (op_q == PWF_OP_ID_ENTRY) ? ((ncmd_q == 3'd3) ? `PWF_CB_ID_SHORT : `PWF_CB_ID_LONG) :
                          `PWF_CB_ID_EXIT;
   wire [7:0] cmd_byte = (step_q == ncmd_q - 3'd1) ? last_byte :
                         (step_q == 3'd0 || step_q == 3'd3) ? `PWF_CB_UNLOCK1 :
                         (step_q == 3'd1 || step_q == 3'd4) ? `PWF_CB_UNLOCK2 : `PWF_CB_EXTEND;
   wire [15:0] cmd_addr = (step_q == 3'd1 || step_q == 3'd4) ? `PWF_CA_EVEN : `PWF_CA_ODD;
   wire [15:0] cur_addr = poll_q ? last_addr_q : in_cmd ? cmd_addr : job_addr_q;
   wire [7:0] cur_data = in_cmd ? cmd_byte : job_data_q;
   wire is_read = poll_q | (~in_cmd & (op_q == PWF_OP_READ || op_q == PWF_OP_HW_ID));
   wire last_step = poll_q | (step_q + 3'd1 >= ncmd_q + {2'b00, has_data_q});
   // Polling: bit 7 must match the last loaded byte (1 after erase) and bit 6 must have stopped toggling.
   wire [7:0] expect_w = poll_erase_q ? 8'hFF : last_data_q;
   wire poll_done = ~poll_first_q & (data_sync[7] == expect_w[7]) & (data_sync[6] == prev6_q);

   // ----------------------------------------------------------------
   // APB slave: one wait-free access phase, answer registered in setup
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h0;
      end else if (clk_en) begin
         pready_q <= psel & ~penable;
         pslverr_q <= psel & ~penable & ~mapped;
         prdata_q <= (psel & ~penable & ~pwrite) ? rd_val : 32'h0;
      end
   end

   // Software registers and sticky errors; a new error wins over its clear.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= `PWF_CTRL_RST;
         addr_q <= 16'h0000;
         wdata_q <= 8'h00;
         err_page_q <= 1'b0;
         err_ref_q <= 1'b0;
      end else if (clk_en) begin
         if (acc_wr & hit_ctrl) ctrl_q <= pwdata[1:0];
         if (acc_wr & hit_addr) addr_q <= pwdata[15:0];
         if (acc_wr & hit_wdata) wdata_q <= pwdata[7:0];
         err_page_q <= (cmd_go & page_bad) | (err_page_q & ~(acc_wr & hit_status & pwdata[`PWF_ST_ERR_PAGE]));
         err_ref_q <= (cmd_go & refuse) | (err_ref_q & ~(acc_wr & hit_status & pwdata[`PWF_ST_ERR_REF]));
      end
   end

   // ----------------------------------------------------------------
   // Pin sequencer
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q <= PWF_ST_IDLE;
         op_q <= PWF_OP_READ;
         step_q <= 3'd0;
         ncmd_q <= 3'd0;
         has_data_q <= 1'b0;
         cnt_q <= 10'd0;
         job_addr_q <= 16'h0000;
         job_data_q <= 8'h00;
         last_addr_q <= 16'h0000;
         last_data_q <= 8'h00;
         rdata_q <= 8'h00;
         loads_q <= 8'h00;
         win_q <= 1'b0;
         win_cnt_q <= 13'd0;
         page_q <= 9'd0;
         poll_q <= 1'b0;
         poll_first_q <= 1'b0;
         poll_erase_q <= 1'b0;
         prev6_q <= 1'b0;
         tmo_q <= 22'd0;
         err_tmo_q <= 1'b0;
         addr_pins_q <= 16'h0000;
         dout_q <= 8'h00;
         doe_q <= 1'b0;
         ce_n_q <= 1'b1;
         oe_n_q <= 1'b1;
         we_n_q <= 1'b1;
         hv_q <= 1'b0;
      end else if (clk_en) begin
         if (win_q && win_cnt_q != 13'd0) win_cnt_q <= win_cnt_q - 13'd1;
         if (poll_q && tmo_q != 22'd0) tmo_q <= tmo_q - 22'd1;
         if (acc_wr & hit_status & pwdata[`PWF_ST_ERR_TMO]) err_tmo_q <= 1'b0;
         unique case (st_q)
            PWF_ST_IDLE: begin
               if (poll_q && tmo_q == 22'd0) begin
                  poll_q <= 1'b0;
                  err_tmo_q <= 1'b1;
               end else if (poll_q) begin
                  st_q <= PWF_ST_SETUP;
               end else if (expire) begin
                  // Loading ended; the flash programs the whole page while software runs on.
                  win_q <= 1'b0;
                  poll_q <= 1'b1;
                  poll_first_q <= 1'b1;
                  poll_erase_q <= 1'b0;
                  tmo_q <= 22'(PROG_CYC);
               end else if (start) begin
                  op_q <= cmd_op;
                  ncmd_q <= ncmd_w;
                  has_data_q <= has_data_w;
                  step_q <= 3'd0;
                  job_addr_q <= addr_q;
                  job_data_q <= wdata_q;
                  st_q <= PWF_ST_SETUP;
               end
            end
            PWF_ST_SETUP: begin
               // Address and data settle before the strobe falls.
               addr_pins_q <= cur_addr;
               dout_q <= cur_data;
               ce_n_q <= 1'b0;
               oe_n_q <= ~is_read;
               doe_q <= ~is_read;
               hv_q <= is_read & ~poll_q & (op_q == PWF_OP_HW_ID);
               st_q <= is_read ? PWF_ST_READ : PWF_ST_STROBE;
               cnt_q <= is_read ? 10'(RD_CYC + 3) : 10'(`PWF_WE_CYC);
            end
            PWF_ST_STROBE: begin
               if (cnt_q != 10'd0) begin
                  we_n_q <= 1'b0;
                  cnt_q <= cnt_q - 10'd1;
               end else begin
                  we_n_q <= 1'b1;
                  st_q <= PWF_ST_HOLD;
               end
            end
            PWF_ST_HOLD, PWF_ST_READ: begin
               if (st_q == PWF_ST_READ && cnt_q != 10'd0) begin
                  cnt_q <= cnt_q - 10'd1;
               end else begin
                  ce_n_q <= 1'b1;
                  oe_n_q <= 1'b1;
                  doe_q <= 1'b0;
                  hv_q <= 1'b0;
                  step_q <= step_q + 3'd1;
                  st_q <= last_step ? PWF_ST_IDLE : PWF_ST_SETUP;
                  if (st_q == PWF_ST_READ) rdata_q <= data_sync;
                  if (poll_q) begin
                     prev6_q <= data_sync[6];
                     poll_first_q <= 1'b0;
                     if (poll_done) poll_q <= 1'b0;
                  end else if (last_step) begin
                     unique case (op_q)
                        PWF_OP_LOAD: begin
                           last_addr_q <= job_addr_q;
                           last_data_q <= job_data_q;
                           page_q <= job_addr_q[15:7];
                           loads_q <= win_q ? loads_q + 8'd1 : 8'd1;
                           win_q <= 1'b1;
                           win_cnt_q <= 13'(WIN_CYC);
                        end
                        PWF_OP_ERASE: begin
                           poll_q <= 1'b1;
                           poll_first_q <= 1'b1;
                           poll_erase_q <= 1'b1;
                           tmo_q <= 22'(ERASE_CYC);
                        end
                        PWF_OP_ID_ENTRY, PWF_OP_ID_EXIT: begin
                           st_q <= PWF_ST_PAUSE;
                           cnt_q <= 10'(`PWF_PAUSE_CYC - 1);
                        end
                        default: begin
                        end
                     endcase
                  end
               end
            end
            PWF_ST_PAUSE: begin
               if (cnt_q == 10'd0) st_q <= PWF_ST_IDLE;
               else cnt_q <= cnt_q - 10'd1;
            end
            default: st_q <= PWF_ST_IDLE;
         endcase
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign address_pins = addr_pins_q;
   assign data_pins_wr = dout_q;
   assign data_pins_oe = doe_q;
   assign chip_sel_n = ce_n_q;
   assign out_gate_n = oe_n_q;
   assign write_strobe_n = we_n_q;
   assign id_high_voltage_pin = hv_q;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   logic [9:0] we_cnt_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) we_cnt_q <= 10'd0;
      else if (clk_en) we_cnt_q <= we_n_q ? 10'd0 : we_cnt_q + 10'd1;
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn || !clk_en);

   sequence s_strobe_fall;
      $fell(we_n_q) && !ce_n_q;
   endsequence
   sequence s_strobe_held;
      $stable(addr_pins_q) && $stable(dout_q) && doe_q;
   endsequence

   gate_strobe_excl_a: assert property (!(!oe_n_q && !we_n_q)) else $error("gate and strobe low together");
   read_no_drive_a: assert property (!oe_n_q |-> !doe_q) else $error("host drives during read");
   write_frame_a: assert property (s_strobe_fall |-> oe_n_q && doe_q) else $error("bad write frame");
   strobe_hold_a: assert property (s_strobe_fall |=> s_strobe_held) else $error("pins moved in strobe");
   strobe_width_a: assert property ($rose(we_n_q) |-> we_cnt_q * `PWF_CLK_NS >= `PWF_WE_MIN_NS)
      else $error("strobe too short");
   page_lock_a: assert property (cmd_go && page_bad |=> err_page_q && st_q == PWF_ST_IDLE)
      else $error("foreign page accepted");
   prefix_first_a: assert property (st_q == PWF_ST_SETUP && !poll_q && op_q == PWF_OP_LOAD && ncmd_q == 3'd3 &&
      step_q == 3'd0 |=> addr_pins_q == `PWF_CA_ODD && dout_q == `PWF_CB_UNLOCK1) else $error("bad prefix");
   erase_last_a: assert property (st_q == PWF_ST_SETUP && !poll_q && op_q == PWF_OP_ERASE && step_q == 3'd5 |=>
      addr_pins_q == `PWF_CA_ODD && dout_q == `PWF_CB_ERASE) else $error("bad erase byte");
   window_end_a: assert property (st_q == PWF_ST_IDLE && !poll_q && expire |=> poll_q && !win_q &&
      tmo_q == 22'(PROG_CYC)) else $error("window end missed");
   poll_tmo_a: assert property (st_q == PWF_ST_IDLE && poll_q && tmo_q == 22'd0 |=> !poll_q && err_tmo_q)
      else $error("poll timeout missed");
   id_pause_a: assert property ($rose(st_q == PWF_ST_PAUSE) |-> cnt_q == 10'(`PWF_PAUSE_CYC - 1))
      else $error("pause length wrong");
   hv_read_a: assert property (hv_q |-> we_n_q && !oe_n_q && !ce_n_q) else $error("id voltage outside read");
endmodule

// file: verif/pwf_flash.sv
// Behavioural byte-wide flash that answers the controller's strobes.
module pwf_flash #(
   parameter int WIN_NS = 900,
   parameter int PROG_NS = 1000,
   parameter int ERASE_NS = 2000,
   parameter logic [7:0] MAKER_ID = 8'h3C, // Arbitrary value.
   parameter logic [7:0] PART_ID = 8'h5A // Arbitrary value.
) (
   input wire logic [15:0] address_pins,
   input wire logic [7:0] din,
   input wire logic chip_sel_n,
   input wire logic out_gate_n,
   input wire logic write_strobe_n,
   input wire logic id_high_voltage_pin,
   output logic [7:0] dout
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [7:0] mem [65536];
   logic [7:0] pb [128];
   bit pv [128];
   logic [15:0] ha [6];
   logic [7:0] hd [6];
   logic [15:0] la, lst;
   logic [7:0] v;
   bit prot = 1'b1;
   bit ld, idm, tog;
   realtime tf, tl, tb;
   wire wr_n = chip_sel_n | write_strobe_n | !out_gate_n;
   wire rd_n = chip_sel_n | out_gate_n;
   function automatic bit s3(input logic [7:0] c);
      return hd[3] == 8'hAA && ha[3] == 16'h5555 && hd[4] == 8'h55 && ha[4] == 16'h2AAA && hd[5] == c;
   endfunction
   function automatic bit s6(input logic [7:0] c);
      return s3(c) && hd[0] == 8'hAA && ha[1] == 16'h2AAA && hd[1] == 8'h55 && hd[2] == 8'h80;
   endfunction
   // The array starts erased.
   initial begin
      foreach (mem[i]) mem[i] = 8'hFF;
      dout = 8'h00;
   end
   // Address is taken on the later falling edge.
   always @(negedge wr_n) begin
      tf = $realtime;
      la = address_pins;
   end
   // Data is taken on the first rising edge; short pulses are dropped.
   always @(posedge wr_n) if ($realtime - tf >= 15) begin
      for (int i = 0; i < 5; i++) begin
         ha[i] = ha[i+1];
         hd[i] = hd[i+1];
      end
      ha[5] = la;
      hd[5] = din;
      if (s3(8'hA0)) begin
         prot = 1'b1;
         ld = 1'b1;
         tl = $realtime;
      end else if (s6(8'h20)) prot = 1'b0;
      else if (s6(8'h10)) begin
         foreach (mem[i]) mem[i] = 8'hFF;
         tb = $realtime + ERASE_NS;
      end else if (s6(8'h60) || s3(8'h90)) idm = 1'b1;
      else if (s3(8'hF0)) idm = 1'b0;
      else if (ld || (!prot && la != 16'h5555 && la != 16'h2AAA)) begin
         pb[la[6:0]] = din;
         pv[la[6:0]] = 1'b1;
         ld = 1'b1;
         lst = la;
         tl = $realtime;
      end
   end
   // Window expiry programs the whole page at once; unloaded bytes become FFh.
   always #10 if (ld && $realtime - tl >= WIN_NS) begin
      ld = 1'b0;
      for (int i = 0; i < 128; i++) begin
         mem[{lst[15:7], i[6:0]}] = pv[i] ? pb[i] : 8'hFF;
         pv[i] = 1'b0;
      end
      tb = $realtime + PROG_NS;
   end
   // Reads give busy status, id codes or the array.
   always @(negedge rd_n) begin
      #1; // Address and id pins launched on the same edge settle first.
      v = ld ? pb[lst[6:0]] : mem[lst];
      if (ld || $realtime < tb) begin
         dout = {~v[7], tog, v[5:0]};
         tog = ~tog;
      end else if ((idm || id_high_voltage_pin) && {address_pins[15:10], address_pins[8:1]} == 14'h0)
         dout = address_pins[0] ? PART_ID : MAKER_ID;
      else
         dout = mem[address_pins];
   end
   // A released bus never keeps its last value.
   always @(posedge rd_n) dout = ~dout;
endmodule

// file: verif/testbench.sv
`include "pwf_defines.svh"
// Bench for the flash controller driven over APB.
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [7:0] MK = 8'h3C; // Arbitrary value.
   localparam logic [7:0] PT = 8'h5A; // Arbitrary value.
   typedef struct {bit w; logic [7:0] a; logic [31:0] d; logic [31:0] x; logic e;} pwf_row_s;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, ev, pready, pslverr;
   logic clk_en = 1'b1;
   logic chip_sel_n, out_gate_n, write_strobe_n, id_high_voltage_pin, data_pins_oe;
   logic [7:0] paddr = 8'h00, data_pins_wr, dout;
   logic [15:0] address_pins;
   logic [31:0] pwdata = 32'h0, prdata, rv;
   int errors = 0, n_tests = 0, cyc = 0;
   wire [7:0] dq = data_pins_oe ? data_pins_wr : dout;
   pwf_row_s rows [5] = '{'{1, `PWF_REG_CTRL, 32'h3, 32'h0, 1'b0}, '{0, `PWF_REG_CTRL, 32'h0, 32'h3, 1'b0},
      '{1, `PWF_REG_ADDR, 32'h1234ABCD, 32'h0, 1'b0}, '{0, `PWF_REG_ADDR, 32'h0, 32'hABCD, 1'b0},
      '{0, 8'h18, 32'h0, 32'h0, 1'b1}};
   pwf_ctrl #(.WIN_CYC(64), .PROG_CYC(200), .ERASE_CYC(400)) dut_u (.pclk, .presetn, .clk_en, .psel, .penable,
      .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .address_pins, .data_pins_rd(dq), .data_pins_wr,
      .data_pins_oe, .chip_sel_n, .out_gate_n, .write_strobe_n, .id_high_voltage_pin);
   pwf_flash #(.MAKER_ID(MK), .PART_ID(PT)) flash_u (.address_pins, .din(dq), .chip_sel_n, .out_gate_n,
      .write_strobe_n, .id_high_voltage_pin, .dout);
   initial forever #10 pclk = ~pclk;
   // Cuts a hang short.
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 60000) begin
         errors++;
         end_sim();
      end
   end
   task automatic end_sim();
      $display("checks %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk(input string s, input logic [31:0] x, input logic [31:0] g);
      n_tests++;
      if (g !== x) begin
         $display("Error %s expected %h seen %h", s, x, g);
         errors++;
      end
   endtask
   // One APB transfer, held until pready is seen.
   task automatic apb(input bit w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rv = prdata;
      ev = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic idle(input logic [1:0] m);
      apb(0, `PWF_REG_STATUS, 32'h0);
      for (int i = 0; i < 3000 && (rv[1:0] & m) != 2'h0; i++) apb(0, `PWF_REG_STATUS, 32'h0);
   endtask
   task automatic op(input logic [2:0] c, input logic [15:0] a, input logic [7:0] d, input logic [1:0] m);
      apb(1, `PWF_REG_ADDR, {16'h0, a});
      apb(1, `PWF_REG_WDATA, {24'h0, d});
      apb(1, `PWF_REG_CMD, {29'h0, c});
      idle(m);
   endtask
   task automatic rd(input logic [15:0] a);
      op(3'h0, a, 8'h00, 2'h3);
      apb(0, `PWF_REG_RDATA, 32'h0);
   endtask
   // Main sequence: reset, register rows, then flash scenarios.
   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      chk("strobes", 32'h7, {29'h0, chip_sel_n, out_gate_n, write_strobe_n});
      chk("data_oe", 32'h0, {31'h0, data_pins_oe});
      foreach (rows[i]) begin
         apb(rows[i].w, rows[i].a, rows[i].d);
         if (!rows[i].w) chk("reg", rows[i].x, rv);
         chk("slverr", {31'h0, rows[i].e}, {31'h0, ev});
      end
      $display("reset and register tests done");
      apb(1, `PWF_REG_CTRL, 32'h1);
      op(3'h1, 16'h0185, 8'h3C, 2'h1);
      op(3'h1, 16'h0182, 8'hC5, 2'h3);
      rd(16'h0185);
      chk("page byte", 32'h3C, rv);
      rd(16'h0181);
      chk("unloaded byte", 32'hFF, rv);
      apb(0, `PWF_REG_STATUS, 32'h0);
      chk("status errors", 32'h0, {29'h0, rv[4:2]});
      apb(1, `PWF_REG_CTRL, 32'h0);
      op(3'h1, 16'h0200, 8'h92, 2'h3);
      rd(16'h0200);
      chk("unprefixed load", 32'hFF, rv);
      apb(1, `PWF_REG_CTRL, 32'h1);
      op(3'h1, 16'h0300, 8'h11, 2'h1);
      op(3'h1, 16'h0400, 8'h22, 2'h1);
      chk("page clash", 32'h1, {31'h0, rv[2]});
      idle(2'h3);
      apb(1, `PWF_REG_STATUS, 32'h1C);
      $display("page tests done");
      for (int k = 0; k < 2; k++) begin
         apb(1, `PWF_REG_CTRL, {30'h0, k[0], 1'b0});
         op(3'h4, 16'h0, 8'h0, 2'h3);
         rd(16'h0000);
         chk("maker id", {24'h0, MK}, rv);
         rd(16'h0001);
         chk("part id", {24'h0, PT}, rv);
         op(3'h5, 16'h0, 8'h0, 2'h3);
         rd(16'h0001);
         chk("id exit", 32'hFF, rv);
      end
      // Hardware id read, frozen by the clock enable in mid-read.
      apb(1, `PWF_REG_ADDR, 32'h0);
      apb(1, `PWF_REG_CMD, 32'h6);
      repeat (2) @(posedge pclk);
      clk_en <= 1'b0;
      repeat (50) @(posedge pclk);
      chk("frozen select", 32'h0, {31'h0, chip_sel_n});
      clk_en <= 1'b1;
      idle(2'h3);
      apb(0, `PWF_REG_RDATA, 32'h0);
      chk("hardware id", {24'h0, MK}, rv);
      $display("id tests done");
      op(3'h2, 16'h0, 8'h0, 2'h3);
      op(3'h1, 16'h0500, 8'h47, 2'h3);
      rd(16'h0500);
      chk("unprotected load", 32'h47, rv);
      op(3'h3, 16'h0, 8'h0, 2'h3);
      rd(16'h0185);
      chk("erased byte", 32'hFF, rv);
      apb(1, `PWF_REG_CMD, 32'h7);
      apb(0, `PWF_REG_STATUS, 32'h0);
      chk("refused op", 32'h1, {31'h0, rv[4]});
      $display("erase tests done");
      end_sim();
   end
endmodule
